/* design/psa_top.sv */
// Purpose: partial area and scroll area settings with AXI4-Lite access
// Assumes: CMD register writes stand in for the command pins
// Notes:   a write to CMD with bit 8 low is a command, high a parameter
// How it works
// (RQ1) partial command 30H takes four parameter bytes
// (RQ2) partial rows are memory row counter values
// (RQ3) equal start and end gives one row
// (RQ4) geometry 00 clamps rows above 219
// (RQ5) geometry 01 clamps rows above 176
// (RQ6) geometry 11 clamps rows above 131
// (RQ7) resets restore start zero, end per geometry
// (RQ8) scroll command 33H takes six bytes, high first
// (RQ9) first scroll value is top fixed lines
// (RQ10) second scroll value is scroll region height
// (RQ11) third scroll value is bottom fixed lines
// (RQ12) scroll region starts after top fixed area
// (RQ13) all scroll counts are memory rows
// (RQ14) host keeps area sum within geometry height
// (RQ15) host keeps row exchange zero while scrolling
// (RQ16) resets restore scroll defaults per geometry
// (RQ17) only data bits 7..0 are used
// (RQ18) refresh order bit picks scan direction
// (RQ19) normal or partial mode on ends scrolling
// (RQ20) reversed order puts bottom fixed area first
// (RQ21) end below start wraps through row zero
`timescale 1ns/1ps
`default_nettype none
module psa_top (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// axi4-lite write address, data and response
	input  wire logic [11:0] i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	// axi4-lite read
	input  wire logic [11:0] i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// settings toward the display timing
	output logic [15:0]      o_partial_start_row,
	output logic [15:0]      o_partial_end_row,
	output logic             o_partial_wraps,
	output logic [15:0]      o_top_fixed_lines,
	output logic [15:0]      o_scroll_region_height,
	output logic [15:0]      o_bottom_fixed_lines,
	output logic [15:0]      o_scroll_first_line,
	output logic             o_vertical_refresh_order,
	output logic             o_vscroll_active
);
	import psa_pkg::*;

	logic [11:0] awaddr_q;
	logic        aw_have_q, w_have_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        wr_go;
	logic [1:0]  geo_q;
	logic        order_q;
	psa_state_t  st_q;
	logic [2:0]  pcnt_q;
	logic [7:0]  hi_q;
	logic [15:0] ps_q, pe_q, tf_q, vs_q, bf_q;
	logic        vscroll_q;
	logic        soft_rst;
	logic        cmd_wr, par_wr;
	logic [7:0]  byte_in;
	logic [15:0] word_in, word_clamped, end_def, vsh_def;

	// write address and data caught in either order
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 12'h000;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
		end else if (wr_go) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= i_wdata;
				wstrb_q  <= i_wstrb;
			end
		end
	end
	assign wr_go = aw_have_q && w_have_q && !o_bvalid;

	// ready flags and write response
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
			o_bvalid  <= 1'b0;
			o_bresp   <= RESP_OKAY;
		end else begin
			o_awready <= !aw_have_q && !(i_awvalid && o_awready) && !o_bvalid;
			o_wready  <= !w_have_q && !(i_wvalid && o_wready) && !o_bvalid;
			if (wr_go) begin
				o_bvalid <= 1'b1;
				o_bresp  <= (awaddr_q == REG_CMD || awaddr_q == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
			end else if (i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// decoded command and parameter writes
	assign cmd_wr   = wr_go && awaddr_q == REG_CMD && wstrb_q[0] && !wdata_q[CMD_DC_BIT];
	assign par_wr   = wr_go && awaddr_q == REG_CMD && wstrb_q[0] && wdata_q[CMD_DC_BIT];
	assign soft_rst = wr_go && awaddr_q == REG_CTRL && wstrb_q[0] && wdata_q[CTRL_SWRST_BIT];
	assign byte_in  = wdata_q[7:0]; // RQ17
	assign word_in  = {hi_q, byte_in}; // RQ8

	// geometry and refresh order controls
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			geo_q   <= GEO_220;
			order_q <= 1'b0;
		end else if (wr_go && awaddr_q == REG_CTRL && wstrb_q[0]) begin
			geo_q   <= wdata_q[CTRL_GEO_LSB +: 2];
			order_q <= wdata_q[CTRL_ORDER_BIT]; // RQ18
		end
	end

	psa_clamp u_clamp (
		.i_geo (geo_q),
		.i_row (word_in),
		.o_row (word_clamped)
	);

	// defaults follow the selected geometry
	always_comb begin
		unique case (geo_q)
			GEO_176: begin
				end_def = END_DEF_176;
				vsh_def = VSH_DEF_176;
			end
			GEO_132: begin
				end_def = END_DEF_132;
				vsh_def = VSH_DEF_132;
			end
			default: begin
				end_def = END_DEF_220;
				vsh_def = VSH_DEF_176;
			end
		endcase
	end

	// command sequencer counts parameter bytes
	always_ff @(posedge i_clk) begin
		if (!i_rstn || soft_rst) begin
			st_q   <= PSA_IDLE;
			pcnt_q <= 3'h0;
			hi_q   <= 8'h00;
		end else if (cmd_wr) begin
			pcnt_q <= 3'h0;
			unique case (byte_in)
				CMD_PARTIAL_AREA: st_q <= PSA_PTL; // RQ1
				CMD_SCROLL_AREA:  st_q <= PSA_SCR; // RQ8
				default:          st_q <= PSA_IDLE;
			endcase
		end else if (par_wr && st_q != PSA_IDLE) begin
			hi_q   <= byte_in;
			pcnt_q <= pcnt_q + 3'h1;
			if ((st_q == PSA_PTL && pcnt_q == PTL_NPARAM - 3'h1) ||
			    (st_q == PSA_SCR && pcnt_q == SCR_NPARAM - 3'h1))
				st_q <= PSA_IDLE;
		end
	end

	// partial rows, clamped, stored as memory rows
	always_ff @(posedge i_clk) begin
		if (!i_rstn || soft_rst) begin
			ps_q <= START_DEF; // RQ7
			pe_q <= i_rstn ? end_def : END_DEF_220; // RQ7
		end else if (par_wr && st_q == PSA_PTL) begin
			if (pcnt_q == 3'h1)
				ps_q <= word_clamped; // RQ2 RQ4 RQ5 RQ6
			if (pcnt_q == 3'h3)
				pe_q <= word_clamped; // RQ4 RQ5 RQ6
		end
	end

	// scroll area counts in memory rows
	always_ff @(posedge i_clk) begin
		if (!i_rstn || soft_rst) begin
			tf_q <= FIXED_DEF; // RQ16
			vs_q <= i_rstn ? vsh_def : VSH_DEF_176; // RQ16
			bf_q <= FIXED_DEF; // RQ16
		end else if (par_wr && st_q == PSA_SCR) begin
			if (pcnt_q == 3'h1)
				tf_q <= word_in; // RQ9 RQ13
			if (pcnt_q == 3'h3)
				vs_q <= word_in; // RQ10 RQ13
			if (pcnt_q == 3'h5)
				bf_q <= word_in; // RQ11 RQ13
		end
	end

	// scroll mode entry and exit
	always_ff @(posedge i_clk) begin
		if (!i_rstn || soft_rst)
			vscroll_q <= 1'b0;
		else if (cmd_wr && (byte_in == CMD_NORMAL_ON || byte_in == CMD_PARTIAL_ON))
			vscroll_q <= 1'b0; // RQ19
		else if (cmd_wr && byte_in == CMD_VSCROLL_ON)
			vscroll_q <= 1'b1;
	end

	// registered settings outputs
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_partial_start_row      <= START_DEF;
			o_partial_end_row        <= END_DEF_220;
			o_partial_wraps          <= 1'b0;
			o_top_fixed_lines        <= FIXED_DEF;
			o_scroll_region_height   <= VSH_DEF_176;
			o_bottom_fixed_lines     <= FIXED_DEF;
			o_scroll_first_line      <= FIXED_DEF;
			o_vertical_refresh_order <= 1'b0;
			o_vscroll_active         <= 1'b0;
		end else begin
			o_partial_start_row      <= ps_q; // RQ3
			o_partial_end_row        <= pe_q;
			o_partial_wraps          <= pe_q < ps_q; // RQ21
			o_top_fixed_lines        <= tf_q;
			o_scroll_region_height   <= vs_q;
			o_bottom_fixed_lines     <= bf_q;
			o_scroll_first_line      <= order_q ? bf_q : tf_q; // RQ12 RQ20
			o_vertical_refresh_order <= order_q;
			o_vscroll_active         <= vscroll_q;
		end
	end

	// read channel
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h00000000;
			o_rresp   <= RESP_OKAY;
		end else if (o_rvalid) begin
			if (i_rready)
				o_rvalid <= 1'b0;
			o_arready <= 1'b0;
		end else if (i_arvalid && o_arready) begin
			o_rvalid  <= 1'b1;
			o_arready <= 1'b0;
			o_rresp   <= RESP_OKAY;
			unique case (i_araddr)
				REG_CTRL:    o_rdata <= {28'h0000000, 1'b0, order_q, geo_q};
				REG_PARTIAL: o_rdata <= {pe_q, ps_q};
				REG_SCROLL0: o_rdata <= {vs_q, tf_q};
				REG_SCROLL1: o_rdata <= {16'h0000, bf_q};
				REG_STATUS:  o_rdata <= {24'h000000, vscroll_q, pe_q < ps_q,
					st_q == PSA_SCR, st_q == PSA_PTL, 1'b0, pcnt_q};
				REG_CMD:     o_rdata <= 32'h00000000;
				default: begin
					o_rdata <= 32'h00000000;
					o_rresp <= RESP_SLVERR;
				end
			endcase
		end else begin
			o_arready <= 1'b1;
		end
	end

	// assertions
	property p_clamp_220;
		@(posedge i_clk) disable iff (!i_rstn) geo_q == GEO_220 |-> ps_q <= ROW_MAX_220 && pe_q <= ROW_MAX_220;
	endproperty
	a_clamp_220: assert property (p_clamp_220) else $error("row above 219"); // RQ4
	property p_clamp_132;
		@(posedge i_clk) disable iff (!i_rstn)
			par_wr && st_q == PSA_PTL && pcnt_q == 3'h3 && geo_q == GEO_132 |=> pe_q <= ROW_MAX_132;
	endproperty
	a_clamp_132: assert property (p_clamp_132) else $error("row above 131"); // RQ6
	property p_clamp_176;
		@(posedge i_clk) disable iff (!i_rstn)
			par_wr && st_q == PSA_PTL && pcnt_q == 3'h1 && geo_q == GEO_176 |=> ps_q <= ROW_MAX_176;
	endproperty
	a_clamp_176: assert property (p_clamp_176) else $error("row above 176"); // RQ5
	property p_tf_cap;
		@(posedge i_clk) disable iff (!i_rstn)
			par_wr && st_q == PSA_SCR && pcnt_q == 3'h1 |=> tf_q == $past(word_in);
	endproperty
	a_tf_cap: assert property (p_tf_cap) else $error("top fixed not captured"); // RQ9
	property p_exit;
		@(posedge i_clk) disable iff (!i_rstn)
			cmd_wr && byte_in == CMD_NORMAL_ON |=> !vscroll_q ##1 !o_vscroll_active;
	endproperty
	a_exit: assert property (p_exit) else $error("scroll mode not left"); // RQ19
	property p_wrap;
		@(posedge i_clk) disable iff (!i_rstn) ##1 o_partial_wraps == $past(pe_q < ps_q);
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap flag wrong"); // RQ21
	property p_first;
		@(posedge i_clk) disable iff (!i_rstn)
			##1 o_scroll_first_line == ($past(order_q) ? $past(bf_q) : $past(tf_q));
	endproperty
	a_first: assert property (p_first) else $error("first scroll line wrong"); // RQ20
	sequence s_ptl_cmd;
		cmd_wr && byte_in == CMD_PARTIAL_AREA;
	endsequence
	property p_ptl_seq;
		@(posedge i_clk) disable iff (!i_rstn) s_ptl_cmd |=> st_q == PSA_PTL && pcnt_q == 3'h0;
	endproperty
	a_ptl_seq: assert property (p_ptl_seq) else $error("partial command not started"); // RQ1
	property p_swrst;
		@(posedge i_clk) disable iff (!i_rstn) soft_rst |=> ps_q == START_DEF && tf_q == FIXED_DEF;
	endproperty
	a_swrst: assert property (p_swrst) else $error("soft reset defaults wrong"); // RQ7
endmodule
`default_nettype wire

/* design/psa_pkg.sv */
// Purpose: constants for the partial and scroll area configuration block
// Assumes: 50 MHz system clock, AXI4-Lite register access
// Notes:   offsets are byte addresses of aligned 32-bit words
package psa_pkg;
	localparam logic [7:0]  CMD_PARTIAL_AREA = 8'h30;
	localparam logic [7:0]  CMD_SCROLL_AREA  = 8'h33;
	localparam logic [7:0]  CMD_PARTIAL_ON   = 8'h12;
	localparam logic [7:0]  CMD_NORMAL_ON    = 8'h13;
	localparam logic [7:0]  CMD_VSCROLL_ON   = 8'h37;
	localparam logic [1:0]  GEO_220          = 2'h0;
	localparam logic [1:0]  GEO_176          = 2'h1;
	localparam logic [1:0]  GEO_132          = 2'h3;
	localparam logic [15:0] ROW_MAX_220      = 16'h00DB;
	localparam logic [15:0] ROW_MAX_176      = 16'h00B0;
	localparam logic [15:0] ROW_MAX_132      = 16'h0083;
	localparam logic [15:0] END_DEF_220      = 16'h00DB;
	localparam logic [15:0] END_DEF_176      = 16'h00AF;
	localparam logic [15:0] END_DEF_132      = 16'h0083;
	localparam logic [15:0] START_DEF        = 16'h0000;
	localparam logic [15:0] FIXED_DEF        = 16'h0000;
	localparam logic [15:0] VSH_DEF_176      = 16'h00B0;
	localparam logic [15:0] VSH_DEF_132      = 16'h0084;
	localparam logic [2:0]  PTL_NPARAM       = 3'h4;
	localparam logic [2:0]  SCR_NPARAM       = 3'h6;
	localparam logic [11:0] REG_CMD          = 12'h000;
	localparam logic [11:0] REG_CTRL         = 12'h004;
	localparam logic [11:0] REG_PARTIAL      = 12'h008;
	localparam logic [11:0] REG_SCROLL0      = 12'h00C;
	localparam logic [11:0] REG_SCROLL1      = 12'h010;
	localparam logic [11:0] REG_STATUS       = 12'h014;
	localparam int          CMD_DC_BIT       = 8;
	localparam int          CTRL_GEO_LSB     = 0;
	localparam int          CTRL_ORDER_BIT   = 2;
	localparam int          CTRL_SWRST_BIT   = 3;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;
	typedef enum logic [1:0] {PSA_IDLE, PSA_PTL, PSA_SCR} psa_state_t;
endpackage

/* design/psa_clamp.sv */
// Purpose: clamp a row value to the last row of the selected geometry
// Assumes: geometry code 10 behaves as the 220-row base
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module psa_clamp (
	// geometry and raw row
	input  wire logic [1:0]  i_geo,
	input  wire logic [15:0] i_row,
	// clamped row
	output logic      [15:0] o_row
);
	import psa_pkg::*;
	logic [15:0] lim;
	// pick the limit and saturate
	always_comb begin
		unique case (i_geo)
			GEO_176: lim = ROW_MAX_176;
			GEO_132: lim = ROW_MAX_132;
			default: lim = ROW_MAX_220;
		endcase
		o_row = (i_row > lim) ? lim : i_row;
	end
endmodule
`default_nettype wire

/* sim/psa_host.sv */
// Purpose: axi4-lite host model that issues register cycles to the settings block
// Assumes: one write and one read at most under way at a time
// Notes:   after the blocking idle values at time zero, every signal changes by nonblocking assignment just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module psa_host (
	// clock
	input  wire logic        i_clk,
	// write channels
	output var logic [11:0]  o_awaddr,
	output var logic         o_awvalid,
	input  wire logic        i_awready,
	output var logic [31:0]  o_wdata,
	output var logic [3:0]   o_wstrb,
	output var logic         o_wvalid,
	input  wire logic        i_wready,
	input  wire logic [1:0]  i_bresp,
	input  wire logic        i_bvalid,
	output var logic         o_bready,
	// read channels
	output var logic [11:0]  o_araddr,
	output var logic         o_arvalid,
	input  wire logic        i_arready,
	input  wire logic [31:0] i_rdata,
	input  wire logic [1:0]  i_rresp,
	input  wire logic        i_rvalid,
	output var logic         o_rready
);
	// idle bus at time zero
	initial begin
		{o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
		{o_araddr, o_arvalid, o_rready} = '0;
		o_wstrb = 4'hF;
	end
	// address and data offered together, each released once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge i_clk);
		o_awaddr  <= a;
		o_wdata   <= d;
		o_awvalid <= 1'b1;
		o_wvalid  <= 1'b1;
		o_bready  <= 1'b1;
		do begin
			@(posedge i_clk);
			if (i_awready) o_awvalid <= 1'b0;
			if (i_wready) o_wvalid <= 1'b0;
		end while (i_bvalid !== 1'b1);
		r = i_bresp;
		o_bready <= 1'b0;
	endtask
	// read held until taken, data captured at the rvalid edge
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_clk);
		o_araddr  <= a;
		o_arvalid <= 1'b1;
		o_rready  <= 1'b1;
		do begin
			@(posedge i_clk);
			if (i_arready) o_arvalid <= 1'b0;
		end while (i_rvalid !== 1'b1);
		d = i_rdata;
		r = i_rresp;
		o_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* sim/partial_and_scroll_area_config_bench.sv */
// Purpose: self-checking bench for the partial and scroll area settings
// Assumes: host model speaks axi4-lite, command bytes go through the cmd register
// Notes:   expectations come from the package constants and literal values in the tests
`timescale 1ns/1ps
`default_nettype none
module partial_and_scroll_area_config_bench;
	import psa_pkg::*;
	logic              clk = 1'b0;
	logic              rstn;
	int                failures, checks_done;
	wire logic [11:0]  awaddr, araddr;
	wire logic [31:0]  wdata, rdata;
	wire logic [3:0]   wstrb;
	wire logic [1:0]   bresp, rresp;
	wire logic         awvalid, awready, wvalid, wready, bvalid, bready;
	wire logic         arvalid, arready, rvalid, rready, wraps, order, active;
	wire logic [15:0]  pstart, pend, tfix, vsh, bfix, first;
	logic [1:0]        geos [3] = '{GEO_220, GEO_176, GEO_132};
	logic [15:0]       maxs [3] = '{ROW_MAX_220, ROW_MAX_176, ROW_MAX_132};
	logic [31:0]       dd;
	logic [1:0]        rr;
	// clock
	always #10 clk = ~clk;
	// design and host
	psa_top i_psa_top (.i_clk(clk), .i_rstn(rstn), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_partial_start_row(pstart),
		.o_partial_end_row(pend), .o_partial_wraps(wraps), .o_top_fixed_lines(tfix),
		.o_scroll_region_height(vsh), .o_bottom_fixed_lines(bfix),
		.o_scroll_first_line(first), .o_vertical_refresh_order(order),
		.o_vscroll_active(active));
	psa_host i_psa_host (.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
		.i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
		.i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
		.o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
		.i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));
	// compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// bus helpers expecting an okay answer
	task automatic w(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] r;
		i_psa_host.wr(a, d, r);
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		i_psa_host.rd(a, d, r);
		chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
		chk("rdata", e, d);
	endtask
	// command and parameter bytes with junk above the byte lane
	task automatic cmd(input logic [7:0] b);
		w(REG_CMD, {23'h5A5A5A, 1'b0, b});
	endtask
	task automatic par(input logic [15:0] v);
		w(REG_CMD, {23'h5A5A5A, 1'b1, v[15:8]});
		w(REG_CMD, {23'h5A5A5A, 1'b1, v[7:0]});
	endtask
	task automatic ptl(input logic [15:0] s, input logic [15:0] e);
		cmd(CMD_PARTIAL_AREA);
		par(s);
		par(e);
	endtask
	// outputs trail the register by a cycle
	task automatic settle();
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	// verdict
	task automatic give_verdict();
		if (failures == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		give_verdict();
	end
	// tests
	initial begin
		failures = 0;
		checks_done = 0;
		rstn = 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rchk(REG_PARTIAL, {END_DEF_220, START_DEF});
		rchk(REG_SCROLL0, {VSH_DEF_176, FIXED_DEF});
		rchk(REG_SCROLL1, {16'h0000, FIXED_DEF});
		ptl(16'h0005, 16'h0010);
		rchk(REG_PARTIAL, 32'h00100005);
		settle();
		chk("start", 32'h5, {16'h0, pstart});
		chk("end", 32'h10, {16'h0, pend});
		ptl(16'h0020, 16'h0010);
		settle();
		chk("wraps", 32'h1, {31'h0, wraps});
		// clamp per geometry; equal rows give no wrap
		for (int k = 0; k < 3; k++) begin
			w(REG_CTRL, {30'h0, geos[k]});
			ptl(maxs[k] + 16'h0001, 16'hFFFF);
			rchk(REG_PARTIAL, {maxs[k], maxs[k]});
			settle();
			chk("wraps", 32'h0, {31'h0, wraps});
		end
		// sum 176 stays inside the 220 base
		w(REG_CTRL, {30'h0, GEO_220});
		cmd(CMD_SCROLL_AREA);
		par(16'h0010);
		par(16'h0080);
		par(16'h0020);
		rchk(REG_SCROLL0, 32'h00800010);
		rchk(REG_SCROLL1, 32'h00000020);
		settle();
		chk("top", 32'h10, {16'h0, tfix});
		chk("height", 32'h80, {16'h0, vsh});
		chk("bottom", 32'h20, {16'h0, bfix});
		chk("first", 32'h10, {16'h0, first});
		w(REG_CTRL, 32'h4);
		settle();
		chk("order", 32'h1, {31'h0, order});
		chk("first", 32'h20, {16'h0, first});
		// scroll mode left by either mode-on command
		cmd(CMD_VSCROLL_ON);
		settle();
		chk("active", 32'h1, {31'h0, active});
		rchk(REG_STATUS, 32'h00000080);
		cmd(CMD_NORMAL_ON);
		settle();
		chk("active", 32'h0, {31'h0, active});
		cmd(CMD_VSCROLL_ON);
		cmd(CMD_PARTIAL_ON);
		settle();
		chk("active", 32'h0, {31'h0, active});
		// refused accesses
		i_psa_host.rd(12'h0FC, dd, rr);
		chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
		chk("rdata", 32'h0, dd);
		i_psa_host.wr(REG_PARTIAL, 32'h00010001, rr);
		chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
		rchk(REG_PARTIAL, {ROW_MAX_132, ROW_MAX_132});
		// soft reset under the 132-row base
		w(REG_CTRL, {30'h0, GEO_132});
		w(REG_CTRL, 32'hB);
		rchk(REG_PARTIAL, {END_DEF_132, START_DEF});
		rchk(REG_SCROLL0, {VSH_DEF_132, FIXED_DEF});
		rchk(REG_SCROLL1, {16'h0000, FIXED_DEF});
		give_verdict();
	end
endmodule
`default_nettype wire
